// ---- src/wlm_pkg.sv ----
// constants shared by the wiper load and mode control block
// Operation
// R1: a load request copies the staged input value into the wiper register
// R2: input register follows the wiper; only staging writes make it differ
// R3: software load updates one selected wiper register or all together
// R4: low load pin copies every input register to its wiper, no selection
// R5: load pin transitions are ignored while a serial command executes
// R6: strap high at power-up selects gain mode, loads both stored codes
// R7: strap low at power-up selects complementary potentiometer mode
// R8: effective mode is strap OR gain mode bit; either blocks potentiometer
// R9: wiper code is 7 or 8 bits, decoded to exactly one tap
// R10: potentiometer mode: B side rises with code, A side falls complementarily
// R11: gain mode: A side is proportional to its own wiper register code
// R12: top scale position cuts the A side by one more LSB step
// R13: tolerance is 16-bit sign magnitude: sign+integer at 0x02, fraction 0x03
// R14: tolerance sign bit: 0 means negative, 1 means positive
// R15: host enables gain mode by control write with gain mode bit set
// R16: load pin is synchronised before it may touch the wiper registers
package wlm_pkg;
    localparam int WIDTH_DEF = 8;
    localparam int NCH = 2;
    localparam int CH_WB = 0;
    localparam int CH_AW = 1;
    localparam logic [7:0] TOL_INT_OFS = 8'h02;
    localparam logic [7:0] TOL_FRAC_OFS = 8'h03;
    localparam int TOL_SIGN_POS = 7;
    localparam logic SIGN_NEG = 1'b0;
    localparam logic SIGN_POS = 1'b1;
    localparam logic [7:0] RD_DATA_RST = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h7;
    localparam logic GAIN_BIT_RST = 1'b0;
    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN = 2'b10
    } wlm_state_e;
endpackage

// ---- src/wlm_tap_decode.sv ----
// registered one-hot tap decoder for one wiper code
`timescale 1ns/1ps
`default_nettype none
module wlm_tap_decode #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] code,
    output logic [(1<<WIDTH)-1:0] tap
);
    logic [(1<<WIDTH)-1:0] tap_next;

    // one comparator per tap keeps exactly one line high
    genvar i;
    generate
        for (i = 0; i < (1 << WIDTH); i++) begin : g_tap
            assign tap_next[i] = (code == WIDTH'(i)); // R9
        end
    endgenerate

    // registered so the switch drive never glitches
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tap <= '0;
        end else begin
            tap <= tap_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_tap_onehot: assert property (!$past(sys_rst) |-> // R9
        ($onehot(tap) && tap[$past(code)]))
        else $error("tap select is not one-hot on the code");
endmodule
`default_nettype wire

// ---- src/wlm_wiper_ctrl.sv ----
// wiper registers, load paths, mode selection and tolerance readback
`timescale 1ns/1ps
`default_nettype none
module wlm_wiper_ctrl #(
    parameter int WIDTH = wlm_pkg::WIDTH_DEF,
    parameter logic [7:0] TOL_INT_BYTE = 8'h00,
    parameter logic [7:0] TOL_FRAC_BYTE = 8'h00
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_busy,
    input wire logic stage_wr,
    input wire logic stage_ch,
    input wire logic [WIDTH-1:0] stage_data,
    input wire logic load_wr,
    input wire logic load_all,
    input wire logic load_ch,
    input wire logic ctrl_wr,
    input wire logic ctrl_gain_mode_bit,
    input wire logic load_wiper_strobe_n,
    input wire logic independent_mode_strap,
    input wire logic [WIDTH-1:0] nv_wb_code,
    input wire logic [WIDTH-1:0] nv_aw_code,
    input wire logic top_scale,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic init_done,
    output logic independent_mode_strap_mode,
    output logic gain_mode_bit,
    output logic tolerance_sign_bit,
    output logic [WIDTH-1:0] wiper_wb_code,
    output logic [WIDTH-1:0] wiper_aw_code,
    output logic [WIDTH-1:0] input_wb_code,
    output logic [WIDTH-1:0] input_aw_code,
    output logic [WIDTH:0] wiper_to_b_resistance,
    output logic [WIDTH:0] a_to_wiper_resistance,
    output logic [(1<<WIDTH)-1:0] tap_wb,
    output logic [(1<<WIDTH)-1:0] tap_aw
);
    localparam logic [WIDTH:0] FULL_STEPS = (WIDTH+1)'(1 << WIDTH);

    wlm_pkg::wlm_state_e state_reg, state_next;
    logic strap_reg;
    logic gain_bit_reg;
    logic [2:0] sync_reg;
    logic [WIDTH-1:0] wiper_reg [wlm_pkg::NCH];
    logic [WIDTH-1:0] input_reg [wlm_pkg::NCH];
    logic [WIDTH-1:0] nv_code [wlm_pkg::NCH];
    logic [WIDTH:0] aw_raw, aw_steps_next, wb_steps_next;
    logic [7:0] rd_data_next;
    logic [7:0] tol_int_byte;

    wire running = (state_reg == wlm_pkg::ST_RUN);
    wire initing = (state_reg == wlm_pkg::ST_INIT);
    // pin is low after sync, was high the cycle before
    wire pin_fall = sync_reg[2] & ~sync_reg[1];
    // a busy serial command masks the pin so no half update happens
    wire pin_load = pin_fall & ~cmd_busy & running; // R5
    wire mode_independent_mode_strap = strap_reg | gain_bit_reg; // R8

    assign nv_code[wlm_pkg::CH_WB] = nv_wb_code;
    assign nv_code[wlm_pkg::CH_AW] = nv_aw_code;

    // one init cycle after reset: strap is caught, stored codes restored
    always_comb begin
        case (state_reg)
            wlm_pkg::ST_INIT: state_next = wlm_pkg::ST_RUN;
            wlm_pkg::ST_RUN: state_next = wlm_pkg::ST_RUN;
            default: state_next = wlm_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= wlm_pkg::ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // strap sampled only at power-up; later pin moves are ignored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_reg <= 1'b0;
        end else if (initing) begin
            strap_reg <= independent_mode_strap; // R6 R7
        end
    end

    // control bit written by the host's control command
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_bit_reg <= wlm_pkg::GAIN_BIT_RST;
        end else if (ctrl_wr && running) begin
            gain_bit_reg <= ctrl_gain_mode_bit; // R15
        end
    end

    // three stages: two to settle the pin, one for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_reg <= wlm_pkg::SYNC_RST;
        end else begin
            sync_reg <= {sync_reg[1:0], load_wiper_strobe_n}; // R16
        end
    end

    // per channel staging and wiper registers
    genvar c;
    generate
        for (c = 0; c < wlm_pkg::NCH; c++) begin : g_ch
            wire sw_hit = load_wr & running & (load_all | (load_ch == 1'(c)));
            wire do_load = sw_hit | pin_load; // R3 R4
            wire do_stage = stage_wr & running & (stage_ch == 1'(c));
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    wiper_reg[c] <= '0;
                    input_reg[c] <= '0;
                end else if (initing) begin
                    wiper_reg[c] <= nv_code[c]; // R6
                    input_reg[c] <= nv_code[c]; // R2
                end else begin
                    if (do_load) begin
                        wiper_reg[c] <= input_reg[c]; // R1
                    end
                    if (do_stage) begin
                        input_reg[c] <= stage_data; // R2
                    end
                end
            end
        end
    endgenerate

    // A side: complementary in pot mode, own register in gain mode
    assign wb_steps_next = {1'b0, wiper_reg[wlm_pkg::CH_WB]}; // R10
    assign aw_raw = mode_independent_mode_strap ? {1'b0, wiper_reg[wlm_pkg::CH_AW]} // R11
                               : FULL_STEPS - wb_steps_next; // R10
    // top scale takes one more step off, floored at zero
    assign aw_steps_next = (top_scale && aw_raw != '0) ? // R12
                           aw_raw - (WIDTH+1)'(1) : aw_raw;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wiper_to_b_resistance <= '0;
            a_to_wiper_resistance <= FULL_STEPS;
        end else begin
            wiper_to_b_resistance <= wb_steps_next;
            a_to_wiper_resistance <= aw_steps_next;
        end
    end

    // factory tolerance bytes, read with one cycle of latency
    assign tol_int_byte = TOL_INT_BYTE; // R13
    assign rd_data_next = (rd_addr == wlm_pkg::TOL_INT_OFS) ? tol_int_byte :
                          (rd_addr == wlm_pkg::TOL_FRAC_OFS) ? TOL_FRAC_BYTE :
                          8'h00; // R13

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= wlm_pkg::RD_DATA_RST;
        end else if (rd_en) begin
            rd_data <= rd_data_next;
        end
    end

    wlm_tap_decode #(.WIDTH(WIDTH)) u_tap_wb (
        .clk(clk),
        .sys_rst(sys_rst),
        .code(wiper_reg[wlm_pkg::CH_WB]),
        .tap(tap_wb)
    );

    wlm_tap_decode #(.WIDTH(WIDTH)) u_tap_aw (
        .clk(clk),
        .sys_rst(sys_rst),
        .code(wiper_reg[wlm_pkg::CH_AW]),
        .tap(tap_aw)
    );

    // status and register views
    assign init_done = running;
    assign independent_mode_strap_mode = mode_independent_mode_strap;
    assign gain_mode_bit = gain_bit_reg;
    assign tolerance_sign_bit = tol_int_byte[wlm_pkg::TOL_SIGN_POS]; // R14
    assign wiper_wb_code = wiper_reg[wlm_pkg::CH_WB];
    assign wiper_aw_code = wiper_reg[wlm_pkg::CH_AW];
    assign input_wb_code = input_reg[wlm_pkg::CH_WB];
    assign input_aw_code = input_reg[wlm_pkg::CH_AW];

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_pin_drop;
        !cmd_busy && running && load_wiper_strobe_n ##1 !load_wiper_strobe_n;
    endsequence

    a_sw_load_one: assert property (load_wr && running && !load_all && // R3
        !load_ch && !pin_load |=>
        wiper_wb_code == $past(input_wb_code) &&
        wiper_aw_code == $past(wiper_aw_code))
        else $error("single channel load touched the wrong wiper");
    a_sw_load_all: assert property (load_wr && load_all && running |=> // R1
        wiper_wb_code == $past(input_wb_code) &&
        wiper_aw_code == $past(input_aw_code))
        else $error("load all did not copy both input registers");
    a_pin_load_all: assert property (s_pin_drop ##0 // R4
        (!cmd_busy && running)[*3] |=>
        wiper_wb_code == $past(input_wb_code) &&
        wiper_aw_code == $past(input_aw_code))
        else $error("load pin did not copy both registers in time");
    a_pin_busy_ignored: assert property (pin_fall && cmd_busy && // R5
        !load_wr |=> $stable(wiper_wb_code) && $stable(wiper_aw_code))
        else $error("load pin acted during a serial command");
    // init restores stored codes, so the init cycle is left out here
    a_no_sync_load: assert property (!initing && $stable(sync_reg) && // R16
        !load_wr |=>
        $stable(wiper_wb_code) && $stable(wiper_aw_code))
        else $error("wiper changed with no load request");
    a_stage_holds: assert property (stage_wr && running && !stage_ch && // R2
        !load_wr && !pin_load |=> input_wb_code == $past(stage_data) &&
        $stable(wiper_wb_code))
        else $error("staging write misbehaved");
    a_strap_mode: assert property (initing |=> // R6
        (independent_mode_strap_mode == ($past(independent_mode_strap) |
        $past(gain_bit_reg))) &&
        wiper_wb_code == $past(nv_wb_code))
        else $error("power-up mode or restore wrong");
    a_mode_or: assert property (ctrl_wr && running |=> // R8
        independent_mode_strap_mode == ($past(ctrl_gain_mode_bit) | strap_reg))
        else $error("mode is not the OR of strap and control bit");
    a_aw_comp: assert property (!mode_independent_mode_strap && !top_scale |=> // R10
        a_to_wiper_resistance == FULL_STEPS - $past(wb_steps_next))
        else $error("complementary A side wrong");
    a_aw_independent_mode_strap: assert property (mode_independent_mode_strap && !top_scale |=> // R11
        a_to_wiper_resistance == {1'b0, $past(wiper_aw_code)})
        else $error("independent A side wrong");
    a_top_scale: assert property (top_scale && aw_raw != '0 |=> // R12
        a_to_wiper_resistance == $past(aw_raw) - (WIDTH+1)'(1))
        else $error("top scale step missing");
    a_tol_read: assert property (rd_en && rd_addr == wlm_pkg::TOL_INT_OFS // R14
        |=> rd_data[wlm_pkg::TOL_SIGN_POS] == tolerance_sign_bit)
        else $error("tolerance sign read back wrong");
endmodule
`default_nettype wire

// ---- sim/wlm_host_model.sv ----
// host side model that issues command strobes and drives the load pin
`timescale 1ns/1ps
`default_nettype none
module wlm_host_model (
    input wire logic clk,
    output logic cmd_busy,
    output logic stage_wr,
    output logic stage_ch,
    output logic [7:0] stage_data,
    output logic load_wr,
    output logic load_all,
    output logic load_ch,
    output logic ctrl_wr,
    output logic ctrl_gain_mode_bit,
    output logic load_wiper_strobe_n,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    // idle levels; the load pin rests high between loads
    initial begin
        {cmd_busy, stage_wr, stage_ch, load_wr, load_all, load_ch} = 6'h00;
        {ctrl_wr, ctrl_gain_mode_bit, rd_en} = 3'h0;
        {stage_data, rd_addr} = 16'h0000;
        load_wiper_strobe_n = 1'b1;
    end
    // strobes rise and fall on rising edges, one cycle wide, the load pin two cycles
    task automatic stage(input logic ch, input logic [7:0] d);
        @(posedge clk);
        {stage_wr, stage_ch, stage_data} <= {1'b1, ch, d};
        @(posedge clk);
        stage_wr <= 1'b0;
    endtask
    task automatic load(input logic all, input logic ch);
        @(posedge clk);
        {load_wr, load_all, load_ch} <= {1'b1, all, ch};
        @(posedge clk);
        load_wr <= 1'b0;
    endtask
    // gain mode is entered through a control write or a high strap at power-up
    task automatic ctrl(input logic g);
        @(posedge clk);
        {ctrl_wr, ctrl_gain_mode_bit} <= {1'b1, g};
        @(posedge clk);
        ctrl_wr <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a);
        @(posedge clk);
        {rd_en, rd_addr} <= {1'b1, a};
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    // busy spans the whole detection window so a masked fall is truly lost
    task automatic pin_load(input logic busy);
        @(posedge clk);
        {load_wiper_strobe_n, cmd_busy} <= {1'b0, busy};
        repeat (2) @(posedge clk);
        load_wiper_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmd_busy <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the wiper load and mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, sys_rst, cmd_busy, stage_wr, stage_ch, load_wr, load_all;
    logic load_ch, ctrl_wr, ctrl_gain_mode_bit, load_wiper_strobe_n;
    logic independent_mode_strap, top_scale, rd_en, init_done, independent_mode_strap_mode;
    logic gain_mode_bit, tolerance_sign_bit;
    logic [7:0] stage_data, nv_wb_code, nv_aw_code, rd_addr, rd_data;
    logic [7:0] wiper_wb_code, wiper_aw_code, input_wb_code, input_aw_code;
    logic [8:0] wiper_to_b_resistance, a_to_wiper_resistance;
    logic [255:0] tap_wb, tap_aw;
    int failures, num_checks, seed, m_w[2], m_in[2], m_gain, m_strap;
    int addrs[3] = '{2, 3, 127};
    logic [7:0] d;

    wlm_wiper_ctrl #(.TOL_INT_BYTE(8'h02), .TOL_FRAC_BYTE(8'hb0))
        i_wlm_wiper_ctrl (.clk, .sys_rst, .cmd_busy, .stage_wr, .stage_ch,
        .stage_data, .load_wr, .load_all, .load_ch, .ctrl_wr,
        .ctrl_gain_mode_bit, .load_wiper_strobe_n, .independent_mode_strap,
        .nv_wb_code, .nv_aw_code, .top_scale, .rd_en, .rd_addr, .rd_data,
        .init_done, .independent_mode_strap_mode, .gain_mode_bit, .tolerance_sign_bit,
        .wiper_wb_code, .wiper_aw_code, .input_wb_code, .input_aw_code,
        .wiper_to_b_resistance, .a_to_wiper_resistance, .tap_wb, .tap_aw);
    wlm_host_model host (.clk, .cmd_busy, .stage_wr, .stage_ch, .stage_data,
        .load_wr, .load_all, .load_ch, .ctrl_wr, .ctrl_gain_mode_bit,
        .load_wiper_strobe_n, .rd_en, .rd_addr);

    // free running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // three falling edges covers resistance and tap pipeline stages
    task automatic settle_check(input string n);
        int aw;
        repeat (3) @(negedge clk);
        aw = (m_gain | m_strap) ? m_w[1] : 256 - m_w[0];
        if (top_scale && aw != 0) aw = aw - 1;
        chk("wiper_wb", wiper_wb_code, m_w[0]);
        chk("wiper_aw", wiper_aw_code, m_w[1]);
        chk("input_wb", input_wb_code, m_in[0]);
        chk("input_aw", input_aw_code, m_in[1]);
        chk("independent_mode_strap_mode", independent_mode_strap_mode, m_gain | m_strap);
        chk("gain_bit", gain_mode_bit, m_gain);
        chk("init_done", init_done, 1);
        chk("res_wb", wiper_to_b_resistance, m_w[0]);
        chk("res_aw", a_to_wiper_resistance, aw);
        chk("tap_wb", tap_wb === (256'h1 << m_w[0]), 1);
        chk("tap_aw", tap_aw === (256'h1 << m_w[1]), 1);
        $display("test %s done", n);
    endtask
    // fresh codes in both input registers, so a wrong channel shows up
    task automatic stage_both;
        for (int c = 0; c < 2; c++) begin
            d = 8'($random(seed));
            host.stage(c[0], d);
            m_in[c] = d;
        end
    endtask
    // reset with a given strap; the model restores stored codes at init
    task automatic do_reset(input logic strap);
        @(posedge clk);
        sys_rst <= 1'b1;
        independent_mode_strap <= strap;
        nv_wb_code <= 8'($random(seed));
        nv_aw_code <= 8'($random(seed));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        m_strap = strap;
        m_gain = 0;
        m_w = '{nv_wb_code, nv_aw_code};
        m_in = m_w;
    endtask

    // watchdog well beyond the roughly 130 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        seed = 17784;
        {sys_rst, independent_mode_strap, top_scale} = 3'b100;
        {nv_wb_code, nv_aw_code} = 16'h0000;
        do_reset(1'b0);
        settle_check("init pot mode");
        for (int i = 0; i < 4; i++) begin
            // top scale at random; the model follows it either way
            @(posedge clk) top_scale <= 1'($random(seed));
            stage_both();
            settle_check("stage");
            host.load(i[1], i[0]);
            if (i[1]) m_w = m_in;
            else m_w[i[0]] = m_in[i[0]];
            settle_check("soft load");
        end
        // pin fall during a busy command must be lost, then honoured
        stage_both();
        host.pin_load(1'b1);
        settle_check("pin masked");
        host.pin_load(1'b0);
        m_w = m_in;
        settle_check("pin load");
        host.ctrl(1'b1);
        m_gain = 1;
        settle_check("gain mode");
        chk("gain_bit", gain_mode_bit, 1);
        @(posedge clk) top_scale <= 1'b1;
        settle_check("top scale gain");
        host.ctrl(1'b0);
        m_gain = 0;
        settle_check("top scale pot");
        foreach (addrs[k]) begin
            host.read(8'(addrs[k]));
            @(negedge clk);
            chk("rd_data", rd_data, k == 0 ? 2 : k == 1 ? 'hb0 : 0);
        end
        chk("sign_bit", tolerance_sign_bit, wlm_pkg::SIGN_NEG);
        $display("test tolerance read done");
        do_reset(1'b1);
        settle_check("init strap high");
        print_verdict();
    end
endmodule
`default_nettype wire
